// >>> hdl/spi_slave_port.sv
`timescale 1ns/100ps
`include "spi_slave_port_consts.svh"
module spi_slave_port
  import spi_slave_port_pkg::*;
#(
  parameter int FIFO_DEPTH = `SPI_RX_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic ss_n,
  output logic sdo,
  output logic sdo_oe_n,
  input wire logic port_enable,
  input wire logic [3:0] serial_port_control,
  input wire logic clock_idle_polarity,
  input wire logic clock_edge_select,
  input wire logic done_clear,
  output logic [7:0] peripheral_flag_reg_one,
  output logic port_done_flag,
  output logic rx_overrun,
  output logic wake_request,
  input wire logic [7:0] tx_data,
  input wire logic tx_write,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);

  // system domain configuration
  logic link_clear_reg;
  logic ss_ctl_reg;
  logic invert_reg;

  // link domain
  logic sck_eff;
  logic port_rst;
  logic [2:0] bit_cnt_reg;
  byte_t rx_shift_reg;
  byte_t rx_byte_reg;
  byte_t tx_shift_reg;
  logic done_tog_reg;
  logic ack_tog_reg;
  logic req_link;
  logic sdo_reg;
  logic wake_reg;

  // crossings into the system domain
  logic [2:0] sys_sync_in;
  logic [2:0] sys_sync_out;
  logic done_sync;
  logic ack_sync;
  logic ss_sync;

  // system domain receive path
  logic done_seen_reg;
  logic byte_event;
  rx_stage_e rx_stage_reg;
  byte_t rx_hold_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  byte_t fifo_out_data;
  logic done_reg;
  logic done_next;
  logic overrun_reg;
  logic overrun_next;
  logic [7:0] flag_reg_one_reg;

  // system domain transmit path
  byte_t tx_hold_reg;
  logic tx_req_reg;
  logic tx_req_next;
  logic tx_ready_reg;
  logic oe_n_reg;

  // config is sampled in the system domain; change it only with the port idle,
  // since the edge selection below feeds the link clock directly
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ss_ctl_reg <= 1'b0;
      invert_reg <= 1'b0;
    end else begin
      ss_ctl_reg <= (serial_port_control == `SPI_MODE_SS_CTL);
      invert_reg <= ~(clock_idle_polarity ^ clock_edge_select);
    end
  end

  // device reset or disable clears the whole link side, toggles included
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      link_clear_reg <= 1'b1;
    end else begin
      link_clear_reg <= !port_enable;
    end
  end

  // sample edge is the rising edge of sck_eff; output changes on the falling
  assign sck_eff = sck ^ invert_reg;

  // select reset spares the toggles, so no phantom byte follows each frame
  assign port_rst = link_clear_reg | (ss_ctl_reg & ss_n);

  bit_sync #(
    .WIDTH(1)
  ) u_req_sync (
    .clock(sck_eff),
    .clear(link_clear_reg),
    .d(tx_req_reg),
    .q(req_link)
  );

  // shifting uses only the master's edges, so it runs while the core sleeps
  always_ff @(posedge sck_eff or posedge port_rst) begin
    if (port_rst) begin
      bit_cnt_reg <= `SPI_CNT_RST;
      rx_shift_reg <= '0;
    end else begin
      rx_shift_reg <= {rx_shift_reg[6:0], sdi};
      if (bit_cnt_reg == `SPI_LAST_BIT) begin
        bit_cnt_reg <= `SPI_CNT_RST;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  end

  // completed byte stays put for eight sck periods, ample for the crossing
  always_ff @(posedge sck_eff or posedge link_clear_reg) begin
    if (link_clear_reg) begin
      rx_byte_reg <= '0;
      done_tog_reg <= 1'b0;
    end else if (!port_rst && bit_cnt_reg == `SPI_LAST_BIT) begin
      rx_byte_reg <= {rx_shift_reg[6:0], sdi};
      done_tog_reg <= ~done_tog_reg;
    end
  end

  // transmit byte is taken at the end of the one before it
  always_ff @(posedge sck_eff or posedge port_rst) begin
    if (port_rst) begin
      tx_shift_reg <= `SPI_TX_IDLE_BYTE;
    end else if (bit_cnt_reg == `SPI_LAST_BIT) begin
      tx_shift_reg <= (req_link != ack_tog_reg) ? tx_hold_reg : `SPI_TX_IDLE_BYTE;
    end else begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
    end
  end

  always_ff @(posedge sck_eff or posedge link_clear_reg) begin
    if (link_clear_reg) begin
      ack_tog_reg <= 1'b0;
    end else if (!port_rst && bit_cnt_reg == `SPI_LAST_BIT && req_link != ack_tog_reg) begin
      ack_tog_reg <= ~ack_tog_reg;
    end
  end

  always_ff @(negedge sck_eff or posedge port_rst) begin
    if (port_rst) begin
      sdo_reg <= 1'b1;
    end else begin
      sdo_reg <= tx_shift_reg[7];
    end
  end

  // wake is a link-domain level: it must rise with the system clock stopped
  always_ff @(posedge sck_eff or posedge port_rst) begin
    if (port_rst) begin
      wake_reg <= 1'b0;
    end else if (bit_cnt_reg == `SPI_LAST_BIT) begin
      wake_reg <= 1'b1;
    end else if (bit_cnt_reg == `SPI_CNT_RST) begin
      wake_reg <= 1'b0;
    end
  end

  assign sdo = sdo_reg;
  assign wake_request = wake_reg;

  assign sys_sync_in = {ss_n, ack_tog_reg, done_tog_reg};

  bit_sync #(
    .WIDTH(3)
  ) u_sys_sync (
    .clock(clock),
    .clear(link_clear_reg),
    .d(sys_sync_in),
    .q(sys_sync_out)
  );

  assign done_sync = sys_sync_out[0];
  assign ack_sync = sys_sync_out[1];
  assign ss_sync = sys_sync_out[2];

  assign byte_event = done_sync ^ done_seen_reg;

  always_ff @(posedge clock) begin
    if (!reset_n || link_clear_reg) begin
      done_seen_reg <= 1'b0;
    end else begin
      done_seen_reg <= done_sync;
    end
  end

  // one-byte holding stage; a full buffer stalls it, and a second byte
  // arriving then is dropped and reported as overrun
  always_ff @(posedge clock) begin
    if (!reset_n || link_clear_reg) begin
      rx_stage_reg <= RX_EMPTY;
      rx_hold_reg <= '0;
    end else begin
      unique case (rx_stage_reg)
        RX_EMPTY: begin
          if (byte_event) begin
            rx_hold_reg <= rx_byte_reg;
            rx_stage_reg <= RX_HELD;
          end
        end
        RX_HELD: begin
          if (fifo_in_ready) begin
            if (byte_event) begin
              rx_hold_reg <= rx_byte_reg;
            end else begin
              rx_stage_reg <= RX_EMPTY;
            end
          end
        end
        default: begin
          rx_stage_reg <= RX_EMPTY;
        end
      endcase
    end
  end

  sync_fifo #(
    .WIDTH(`SPI_BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(rx_stage_reg == RX_HELD),
    .in_ready(fifo_in_ready),
    .in_data(rx_hold_reg),
    .out_valid(fifo_out_valid),
    .out_ready(rx_ready),
    .out_data(fifo_out_data)
  );

  assign rx_valid = fifo_out_valid;
  assign rx_data = fifo_out_data;

  // a byte landing in the clear cycle keeps the flag set
  always_comb begin
    done_next = done_reg;
    overrun_next = overrun_reg;
    if (done_clear) begin
      done_next = 1'b0;
      overrun_next = 1'b0;
    end
    if (byte_event) begin
      done_next = 1'b1;
    end
    if (byte_event && rx_stage_reg == RX_HELD && !fifo_in_ready) begin
      overrun_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
      overrun_reg <= 1'b0;
      flag_reg_one_reg <= 8'h00;
    end else begin
      done_reg <= done_next;
      overrun_reg <= overrun_next;
      flag_reg_one_reg <= 8'h00;
      flag_reg_one_reg[`SPI_DONE_FLAG_BIT] <= done_next;
    end
  end

  assign port_done_flag = done_reg;
  assign rx_overrun = overrun_reg;
  assign peripheral_flag_reg_one = flag_reg_one_reg;

  // hold register only changes while no request is outstanding
  always_comb begin
    tx_req_next = tx_req_reg;
    if (tx_write && tx_ready_reg) begin
      tx_req_next = ~tx_req_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || link_clear_reg) begin
      tx_hold_reg <= `SPI_TX_IDLE_BYTE;
      tx_req_reg <= 1'b0;
      tx_ready_reg <= 1'b0;
    end else begin
      if (tx_write && tx_ready_reg) begin
        tx_hold_reg <= tx_data;
      end
      tx_req_reg <= tx_req_next;
      tx_ready_reg <= (tx_req_next == ack_sync) && !(tx_write && tx_ready_reg);
    end
  end

  assign tx_ready = tx_ready_reg;

  // driver released while disabled or deselected under select control
  always_ff @(posedge clock) begin
    if (!reset_n || link_clear_reg) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= ss_ctl_reg & ss_sync;
    end
  end

  assign sdo_oe_n = oe_n_reg;

endmodule

// >>> hdl/spi_slave_port_consts.svh
`ifndef SPI_SLAVE_PORT_CONSTS_SVH
`define SPI_SLAVE_PORT_CONSTS_SVH

// data width of one serial byte
`define SPI_BYTE_W 8
// last bit index of the per-byte shift count
`define SPI_LAST_BIT 3'h7
// bit counter reset value
`define SPI_CNT_RST 3'h0
// mode field value that hands reset control to the select pin
`define SPI_MODE_SS_CTL 4'h4
// mode field reset value
`define SPI_MODE_RST 4'h0
// position of the done flag inside the first peripheral flag register
`define SPI_DONE_FLAG_BIT 3
// byte shifted out when nothing was queued for transmission
`define SPI_TX_IDLE_BYTE 8'hFF
// depth of the receive buffer
`define SPI_RX_FIFO_DEPTH 32
// link clock period seen in the bench, in ns
`define SPI_LINK_PERIOD_NS 80
// system clock period, in ns
`define SPI_SYS_PERIOD_NS 100

`endif

// >>> hdl/spi_slave_port_pkg.sv
package spi_slave_port_pkg;

  // holding stage between the link crossing and the receive buffer
  typedef enum logic [1:0] {
    RX_EMPTY = 2'b01,
    RX_HELD  = 2'b10
  } rx_stage_e;

  typedef logic [7:0] byte_t;

endpackage

// >>> hdl/bit_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser; first stage is read only by the second
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic clear,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or posedge clear) begin
    if (clear) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// >>> hdl/sync_fifo.sv
`timescale 1ns/100ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
    end
  end

  // flags are flops so both handshakes stay glitch free
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready <= (count_next != (AW+1)'(DEPTH));
      out_valid <= (count_next != '0);
    end
  end

endmodule

// >>> dv/spi_slave_port_asserts.sv
`timescale 1ns/100ps
module spi_slave_port_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic sdo,
  input wire logic [3:0] serial_port_control,
  input wire logic done_clear,
  input wire logic [7:0] peripheral_flag_reg_one,
  input wire logic port_done_flag,
  input wire logic wake_request,
  input wire logic tx_write,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  flag_map_a: assert property (@(posedge clock) disable iff (!reset_n)
    peripheral_flag_reg_one == {4'h0, port_done_flag, 3'h0}) else $error("flag map");
  wake_done_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(wake_request) |-> ##[0:6] port_done_flag) else $error("no done");
  done_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    port_done_flag && !done_clear |=> port_done_flag) else $error("done lost");
  done_fall_a: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(port_done_flag) |-> $past(done_clear)) else $error("done fell");
  // reset itself is the cause here, so no disable
  reset_clear_a: assert property (@(posedge clock)
    !reset_n |=> !port_done_flag && !tx_ready && !rx_valid) else $error("reset");
  tx_taken_a: assert property (@(posedge clock) disable iff (!reset_n)
    tx_write && tx_ready |=> !tx_ready) else $error("tx not taken");
  rx_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx moved");
  select_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    (serial_port_control == 4'h4 && ss_n) [*2] |-> !wake_request && sdo)
    else $error("select reset");
  wake_span_a: assert property (@(posedge sck) disable iff (!reset_n)
    $rose(wake_request) |=> !wake_request) else $error("wake span");
  cover property (@(posedge clock) $rose(port_done_flag));
  cover property (@(posedge clock) rx_valid && rx_ready);
  cover property (@(posedge clock) ss_n && serial_port_control == 4'h4);
endmodule
bind spi_slave_port spi_slave_port_asserts spi_slave_port_asserts_inst (
  .clock(clock), .reset_n(reset_n), .sck(sck), .ss_n(ss_n), .sdo(sdo),
  .serial_port_control(serial_port_control), .done_clear(done_clear),
  .peripheral_flag_reg_one(peripheral_flag_reg_one), .port_done_flag(port_done_flag),
  .wake_request(wake_request), .tx_write(tx_write), .tx_ready(tx_ready),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

// >>> dv/spi_master_model.sv
`timescale 1ns/100ps
module spi_master_model (
  output logic sck,
  output logic sdi,
  output logic ss_n,
  input wire logic sdo
);
  logic lead_sample;
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    ss_n = 1'b1;
    lead_sample = 1'b1;
  end
  // only with the port held in select reset: the idle move is a clock edge
  task automatic set_mode(input logic idle, input logic lead);
    sck = idle;
    lead_sample = lead;
  endtask
  // sck stands at its idle level outside frames; 80 ns per bit;
  // lead_sample low puts the slave's output edge first
  task automatic shift(input logic [7:0] mo, input int nb, output logic [7:0] mi);
    ss_n = 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      if (lead_sample) sdi = mo[i];
      #40 sck = ~sck;
      if (lead_sample) mi = {mi[6:0], sdo};
      else sdi = mo[i];
      #40 sck = ~sck;
      if (!lead_sample) mi = {mi[6:0], sdo};
    end
    // moving sdi now would race the slave's last sample edge
    if (lead_sample) sdi = ~sdi;
  endtask
  task automatic deselect();
    ss_n = 1'b1;
    #400;
  endtask
endmodule

// >>> dv/spi_slave_port_test.sv
`timescale 1ns/100ps
module spi_slave_port_test;
  logic clock = 1'b0;
  logic reset_n, sck, sdi, ss_n, sdo, sdo_oe_n, port_enable, clock_idle_polarity;
  logic clock_edge_select, done_clear, port_done_flag, rx_overrun, wake_request;
  logic tx_write, tx_ready, rx_valid, rx_ready, run;
  logic [3:0] serial_port_control;
  logic [7:0] peripheral_flag_reg_one, tx_data, rx_data, got;
  int num_errors = 0;
  int n_checks = 0;

  spi_slave_port spi_slave_port_inst (.clock(clock), .reset_n(reset_n), .sck(sck),
    .sdi(sdi), .ss_n(ss_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .port_enable(port_enable),
    .serial_port_control(serial_port_control), .clock_idle_polarity(clock_idle_polarity),
    .clock_edge_select(clock_edge_select), .done_clear(done_clear),
    .peripheral_flag_reg_one(peripheral_flag_reg_one), .port_done_flag(port_done_flag),
    .rx_overrun(rx_overrun), .wake_request(wake_request), .tx_data(tx_data),
    .tx_write(tx_write), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready));
  spi_master_model spi_master_model_inst (.sck(sck), .sdi(sdi), .ss_n(ss_n), .sdo(sdo));

  // gating stands in for sleep: the system clock halts low
  initial begin
    run = 1'b1;
    forever #50 if (run) clock = ~clock;
  end

  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic check1(input logic g, input logic e);
    check8({7'h00, g}, {7'h00, e});
  endtask
  task automatic xfer(input logic [7:0] mo, input int nb);
    spi_master_model_inst.shift(mo, nb, got);
  endtask
  task automatic put_tx(input logic [7:0] v);
    @(negedge clock);
    tx_data = v;
    tx_write = 1'b1;
    @(negedge clock);
    tx_write = 1'b0;
  endtask
  task automatic pop_rx(input logic [7:0] e);
    @(negedge clock);
    for (int i = 0; i < 40 && rx_valid !== 1'b1; i++) @(negedge clock);
    check1(rx_valid, 1'b1);
    check8(rx_data, e);
    rx_ready = 1'b1;
    @(negedge clock);
    rx_ready = 1'b0;
  endtask

  task automatic t_reset();
    check1(sdo_oe_n, 1'b1);
    check8(peripheral_flag_reg_one, 8'h00);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    check1(tx_ready, 1'b1);
  endtask
  task automatic t_bytes();
    put_tx(8'h3C);
    xfer(8'hA5, 8);
    check8(got, 8'hFF);
    check1(sdo_oe_n, 1'b0);
    xfer(8'h5A, 8);
    check8(got, 8'h3C);
    xfer(8'hC3, 8);
    check8(got, 8'hFF);
    repeat (6) @(negedge clock);
    check1(wake_request, 1'b1);
    check8(peripheral_flag_reg_one, 8'h08);
    spi_master_model_inst.deselect();
    check1(wake_request, 1'b0);
    pop_rx(8'hA5);
    pop_rx(8'h5A);
    pop_rx(8'hC3);
    done_clear = 1'b1;
    @(negedge clock);
    done_clear = 1'b0;
    @(negedge clock);
    check1(port_done_flag, 1'b0);
  endtask
  task automatic t_sleep();
    @(negedge clock);
    run = 1'b0;
    xfer(8'h77, 8);
    check1(wake_request, 1'b1);
    run = 1'b1;
    repeat (6) @(negedge clock);
    check1(port_done_flag, 1'b1);
    spi_master_model_inst.deselect();
    pop_rx(8'h77);
  endtask
  task automatic t_select();
    xfer(8'h0F, 4);
    spi_master_model_inst.deselect();
    check1(sdo, 1'b1);
    xfer(8'h96, 8);
    check8(got, 8'hFF);
    spi_master_model_inst.deselect();
    pop_rx(8'h96);
  endtask
  // far side stalls: 32 in buffer, one held, the last dropped
  task automatic t_fill();
    for (int i = 0; i < 34; i++) xfer(i[7:0], 8);
    spi_master_model_inst.deselect();
    check1(rx_overrun, 1'b1);
    for (int i = 0; i < 33; i++) pop_rx(i[7:0]);
    repeat (2) @(negedge clock);
    check1(rx_valid, 1'b0);
    done_clear = 1'b1;
    @(negedge clock);
    done_clear = 1'b0;
    check1(rx_overrun, 1'b0);
  endtask
  // inverted sample edge: select control off, then idle-high clock with it on
  task automatic t_modes();
    @(negedge clock);
    clock_edge_select = 1'b0;
    repeat (2) @(negedge clock);
    serial_port_control = 4'h0;
    spi_master_model_inst.set_mode(1'b0, 1'b0);
    repeat (2) @(negedge clock);
    put_tx(8'h69);
    xfer(8'hE1, 8);
    check8(got, 8'hFF);
    xfer(8'h1E, 8);
    check8(got, 8'h69);
    spi_master_model_inst.deselect();
    check1(wake_request, 1'b1);
    check1(sdo_oe_n, 1'b0);
    pop_rx(8'hE1);
    pop_rx(8'h1E);
    serial_port_control = 4'h4;
    clock_idle_polarity = 1'b1;
    clock_edge_select = 1'b1;
    repeat (3) @(negedge clock);
    check1(wake_request, 1'b0);
    check1(sdo_oe_n, 1'b1);
    spi_master_model_inst.set_mode(1'b1, 1'b1);
    xfer(8'h4B, 8);
    check8(got, 8'hFF);
    spi_master_model_inst.deselect();
    pop_rx(8'h4B);
  endtask

  initial begin
    reset_n = 1'b0;
    port_enable = 1'b1;
    serial_port_control = 4'h4;
    clock_idle_polarity = 1'b0;
    clock_edge_select = 1'b1;
    done_clear = 1'b0;
    tx_data = 8'h00;
    tx_write = 1'b0;
    rx_ready = 1'b0;
    repeat (20) @(negedge clock);
    t_reset();
    t_bytes();
    t_sleep();
    t_select();
    t_fill();
    t_modes();
    end_of_test();
  end
  // whole sequence needs well under 80 us
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule
